// file: include/mpc_defines.svh
/*
 * Register map, field positions, reset values and carrier constants
 * for the motor PWM compare and conduction block.
 * Assumes byte addresses on a 32-bit classic Wishbone port.
 */
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MPC_ADR_CMP_V      8'h00
`define MPC_ADR_CMP_W      8'h04
`define MPC_ADR_COND       8'h08
`define MPC_ADR_OUTSET     8'h0C
`define MPC_ADR_STATUS     8'h10

// ****************************************
// Field positions and masks
// ****************************************
`define MPC_COND_MASK      32'h0000073F
`define MPC_OUTSET_MASK    32'h0000030F
`define MPC_COND_SEL_LSB   8
`define MPC_OS_TRIG_LSB    8
`define MPC_OS_POLH_BIT    3
`define MPC_OS_POLL_BIT    2
`define MPC_OS_CSYNC_LSB   0

// ****************************************
// Reset values and carrier points
// ****************************************
`define MPC_RST_WORD       32'h00000000
`define MPC_RST_HALF       16'h0000
`define MPC_CNT_BOTTOM     16'h0001

`endif

// file: include/mpc_pkg.sv
/*
 * Types shared by the compare stage and the conduction top.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mpc_pkg;

    typedef logic [15:0] mpc_word_t;

    // Carrier-sync point select
    typedef enum logic [1:0] {
        MPC_CS_IMM  = 2'b00,
        MPC_CS_BOT  = 2'b01,
        MPC_CS_PEAK = 2'b10,
        MPC_CS_BOTH = 2'b11
    } mpc_csync_t;

    // Trigger-sync source select
    typedef enum logic [1:0] {
        MPC_TS_NONE = 2'b00,
        MPC_TS_ENC  = 2'b01,
        MPC_TS_TMR  = 2'b10,
        MPC_TS_RSVD = 2'b11
    } mpc_trig_t;

endpackage

// file: core/mpc_cmp_stage.sv
/*
 * One double-buffered phase compare register and its comparator.
 * Assumes the carrier counter and period come from the carrier logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_defines.svh"

module mpc_cmp_stage (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Bus side
    input  wire logic              wr_en,
    input  wire logic [1:0]        wr_be,
    input  wire mpc_pkg::mpc_word_t wr_data,
    // Carrier side
    input  wire logic              load,
    input  wire mpc_pkg::mpc_word_t cnt,
    input  wire mpc_pkg::mpc_word_t prd,
    // Results
    output mpc_pkg::mpc_word_t     first_q,
    output logic                   active_q
);
    import mpc_pkg::*;

    mpc_word_t second_q;
    wire       over_prd;
    wire       active_d;

    assign over_prd = (second_q > prd);
    // counter below compare; width scales with counter step rate
    assign active_d = over_prd || (cnt < second_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= `MPC_RST_HALF;
        end else if (wr_en) begin
            if (wr_be[0]) first_q[7:0] <= wr_data[7:0];
            if (wr_be[1]) first_q[15:8] <= wr_data[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            second_q <= `MPC_RST_HALF;
            active_q <= 1'b0;
        end else begin
            if (load) second_q <= first_q;
            active_q <= active_d;
        end
    end

    property p_cmp_src;
        @(posedge clk) disable iff (!rst_n)
        load |=> (second_q == $past(first_q));
    endproperty
    a_cmp_src: assert property (p_cmp_src) else $error("second stage not loaded from first");

    property p_full_duty;
        @(posedge clk) disable iff (!rst_n)
        (second_q > prd) |=> active_q;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("compare above period lost full duty");

    property p_active;
        @(posedge clk) disable iff (!rst_n)
        (second_q <= prd) |=> (active_q == ($past(cnt) < $past(second_q)));
    endproperty
    a_active: assert property (p_active) else $error("pwm active does not follow compare");

endmodule
`default_nettype wire

// file: core/mpc_top.sv
/*
 * V/W phase compare stage plus conduction control output stage.
 * Assumes carrier counter, period, unit enable, carrier shape and the
 * compare load strobe come from the carrier logic on the same clock;
 * interrupt triggers are one-cycle pulses on that clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_defines.svh"

// Operation
// - V and W compare hold 16 bits, upper half reads zero.
// - Compare above carrier period gives full duty on that phase.
// - Comparator uses the second-stage compare buffer against the counter.
// - Pulse width is compare value times counter step of 1, 2, 4 or 8 clocks.
// - Compare reads return the last bus-written first stage.
// - Six outputs follow double-buffered conduction control and output setting.
// - Per phase select bit picks PWM or fixed level from conduction bits.
// - Bit 3 sets upper outputs active low at 0, high at 1.
// - Bit 2 sets lower outputs active low at 0, high at 1.
// - Bits 9-8 pick trigger: none, encoder, timer; 11 reserved.
// - Bits 1-0 pick transfer point: immediate, bottom, peak, both.
// - With both syncs set, transfer at first point after each trigger.
// - Carrier sync 11 with trigger transfers at whichever point comes first.
// - Sawtooth carrier makes any nonzero carrier sync transfer at peak.
// - Unit disabled makes conduction transfer immediate.
// - Disabling the unit clears a pending trigger.
// - PWM mode: 00/11 PWM both, 01 upper low, 10 lower low.
module mpc_top (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic                    wb_ack_o,
    output logic [31:0]             wb_dat_o,
    // Carrier logic
    input  wire mpc_pkg::mpc_word_t carrier_cnt,
    input  wire mpc_pkg::mpc_word_t carrier_prd,
    input  wire logic               carrier_tri,
    input  wire logic               unit_enable,
    input  wire logic               cmp_load,
    input  wire logic               u_pwm_active,
    // Trigger sources
    input  wire logic               encoder_interrupt,
    input  wire logic               timer_interrupt,
    // Phase outputs
    output logic                    upper_out_a,
    output logic                    upper_out_b,
    output logic                    upper_out_c,
    output logic                    lower_out_a,
    output logic                    lower_out_b,
    output logic                    lower_out_c
);
    import mpc_pkg::*;

    // ****************************************
    // Bus slave
    // ****************************************
    logic        ack_q;
    logic [31:0] rdat_q;
    wire         bus_req;
    wire         bus_wr;
    wire  [31:0] rdat_d;

    // Ack one cycle after the request, write lands on the ack edge
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr  = bus_req && wb_we_i && ack_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = ((old & ~m) | (nw & m)) & mask;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= `MPC_RST_WORD;
        end else begin
            ack_q  <= bus_req && !ack_q;
            rdat_q <= (bus_req && !ack_q) ? rdat_d : rdat_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ****************************************
    // Compare stages
    // ****************************************
    wire        wr_cmp_v;
    wire        wr_cmp_w;
    mpc_word_t  cmp_v_first;
    mpc_word_t  cmp_w_first;
    logic       v_active;
    logic       w_active;

    assign wr_cmp_v = bus_wr && hit(wb_adr_i, `MPC_ADR_CMP_V);
    assign wr_cmp_w = bus_wr && hit(wb_adr_i, `MPC_ADR_CMP_W);

    mpc_cmp_stage u_cmp_v (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_en    (wr_cmp_v),
        .wr_be    (wb_sel_i[1:0]),
        .wr_data  (wb_dat_i[15:0]),
        .load     (cmp_load || !unit_enable),
        .cnt      (carrier_cnt),
        .prd      (carrier_prd),
        .first_q  (cmp_v_first),
        .active_q (v_active)
    );

    mpc_cmp_stage u_cmp_w (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_en    (wr_cmp_w),
        .wr_be    (wb_sel_i[1:0]),
        .wr_data  (wb_dat_i[15:0]),
        .load     (cmp_load || !unit_enable),
        .cnt      (carrier_cnt),
        .prd      (carrier_prd),
        .first_q  (cmp_w_first),
        .active_q (w_active)
    );

    // ****************************************
    // Conduction and output setting registers
    // ****************************************
    logic [31:0] cond_buf_q;
    logic [31:0] cond_act_q;
    logic [31:0] outset_q;
    wire  [31:0] cond_buf_d;
    wire         wr_cond;
    wire         wr_outset;

    assign wr_cond    = bus_wr && hit(wb_adr_i, `MPC_ADR_COND);
    assign wr_outset  = bus_wr && hit(wb_adr_i, `MPC_ADR_OUTSET);
    assign cond_buf_d = wr_cond ? merge(cond_buf_q, wb_dat_i, wb_sel_i, `MPC_COND_MASK) : cond_buf_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_buf_q <= `MPC_RST_WORD;
            outset_q   <= `MPC_RST_WORD;
        end else begin
            cond_buf_q <= cond_buf_d;
            if (wr_outset) outset_q <= merge(outset_q, wb_dat_i, wb_sel_i, `MPC_OUTSET_MASK);
        end
    end

    // ****************************************
    // Transfer timing
    // ****************************************
    mpc_csync_t csync;
    mpc_trig_t  tsel;
    mpc_word_t  cnt_prev_q;
    logic       pend_q;
    wire        cnt_moved;
    wire        peak_hit;
    wire        bot_hit;
    wire        point_hit;
    wire        trig_hit;
    wire        trig_on;
    wire        xfer;

    assign tsel = mpc_trig_t'(outset_q[`MPC_OS_TRIG_LSB +: 2]);
    assign csync = mpc_csync_t'(outset_q[`MPC_OS_CSYNC_LSB +: 2]);

    // Points fire once per counter step, a held count would repeat them
    assign cnt_moved = (carrier_cnt != cnt_prev_q);
    assign peak_hit  = cnt_moved && (carrier_cnt == carrier_prd);
    assign bot_hit   = cnt_moved && (carrier_cnt == `MPC_CNT_BOTTOM);

    assign point_hit = !carrier_tri ? peak_hit :
                       (csync == MPC_CS_BOT)  ? bot_hit :
                       (csync == MPC_CS_PEAK) ? peak_hit :
                       (peak_hit || bot_hit);

    // Reserved trigger code behaves as no trigger
    assign trig_on  = (tsel == MPC_TS_ENC) || (tsel == MPC_TS_TMR);
    assign trig_hit = ((tsel == MPC_TS_ENC) && encoder_interrupt) ||
                      ((tsel == MPC_TS_TMR) && timer_interrupt);

    // disabled is immediate; pending trigger waits for point
    assign xfer = !unit_enable ? 1'b1 :
                  (!trig_on && csync == MPC_CS_IMM) ? 1'b1 :
                  (!trig_on) ? point_hit :
                  (csync == MPC_CS_IMM) ? trig_hit :
                  (pend_q && point_hit);

    // disable clears pending; a new trigger wins over the consume
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (!unit_enable || !trig_on || csync == MPC_CS_IMM) begin
            pend_q <= 1'b0;
        end else if (trig_hit) begin
            pend_q <= 1'b1;
        end else if (point_hit) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_prev_q <= `MPC_RST_HALF;
            cond_act_q <= `MPC_RST_WORD;
        end else begin
            cnt_prev_q <= carrier_cnt;
            if (xfer) cond_act_q <= cond_buf_d;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    wire [31:0] status_w;

    assign status_w = {18'h0, w_active, v_active, pend_q, cond_act_q[10:0]};

    // first stage read; upper half zero
    assign rdat_d = hit(wb_adr_i, `MPC_ADR_CMP_V)  ? {16'h0, cmp_v_first} :
                    hit(wb_adr_i, `MPC_ADR_CMP_W)  ? {16'h0, cmp_w_first} :
                    hit(wb_adr_i, `MPC_ADR_COND)   ? cond_buf_q :
                    hit(wb_adr_i, `MPC_ADR_OUTSET) ? outset_q :
                    hit(wb_adr_i, `MPC_ADR_STATUS) ? status_w : `MPC_RST_WORD;

    // ****************************************
    // Output stage
    // ****************************************
    wire [2:0] pwm_p;
    wire [2:0] up_lvl;
    wire [2:0] lo_lvl;
    logic [2:0] up_q;
    logic [2:0] lo_q;
    wire       pol_up;
    wire       pol_lo;

    assign pwm_p  = {w_active, v_active, u_pwm_active};
    assign pol_up = outset_q[`MPC_OS_POLH_BIT];
    assign pol_lo = outset_q[`MPC_OS_POLL_BIT];

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_phase
            wire       sel_pwm;
            wire [1:0] oc;
            assign sel_pwm = cond_act_q[`MPC_COND_SEL_LSB + g];
            assign oc      = cond_act_q[2*g +: 2];
            // fixed level; pwm shaping, lower is complement
            assign up_lvl[g] = !sel_pwm ? oc[1] : (oc == 2'b01) ? 1'b0 : pwm_p[g];
            assign lo_lvl[g] = !sel_pwm ? oc[0] : (oc == 2'b10) ? 1'b0 : !pwm_p[g];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 3'h0;
            lo_q <= 3'h0;
        end else begin
            up_q <= up_lvl ^ {3{!pol_up}};
            lo_q <= lo_lvl ^ {3{!pol_lo}};
        end
    end

    assign upper_out_a = up_q[0];
    assign upper_out_b = up_q[1];
    assign upper_out_c = up_q[2];
    assign lower_out_a = lo_q[0];
    assign lower_out_b = lo_q[1];
    assign lower_out_c = lo_q[2];

    // ****************************************
    // Checks
    // ****************************************
    sequence s_armed;
        unit_enable && trig_on && (csync != MPC_CS_IMM) && pend_q && point_hit;
    endsequence

    sequence s_bus_read(logic [7:0] ofs);
        bus_req && !wb_we_i && !ack_q && hit(wb_adr_i, ofs) ##1 ack_q;
    endsequence

    property p_read_first;
        @(posedge clk) disable iff (!rst_n)
        s_bus_read(`MPC_ADR_CMP_V) |-> (wb_dat_o == {16'h0, cmp_v_first});
    endproperty
    a_read_first: assert property (p_read_first) else $error("compare read not first stage");

    property p_rsvd_zero;
        @(posedge clk) disable iff (!rst_n)
        s_bus_read(`MPC_ADR_OUTSET) |-> ((wb_dat_o & ~`MPC_OUTSET_MASK) == 32'h0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved setting bits not zero");

    property p_async_off;
        @(posedge clk) disable iff (!rst_n)
        !unit_enable |=> (cond_act_q == $past(cond_buf_d));
    endproperty
    a_async_off: assert property (p_async_off) else $error("disabled transfer not immediate");

    property p_pend_clear;
        @(posedge clk) disable iff (!rst_n)
        !unit_enable |=> !pend_q;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending trigger survived disable");

    property p_trig_point;
        @(posedge clk) disable iff (!rst_n)
        s_armed |=> (cond_act_q == $past(cond_buf_d));
    endproperty
    a_trig_point: assert property (p_trig_point) else $error("armed point did not transfer");

    property p_no_early;
        @(posedge clk) disable iff (!rst_n)
        (unit_enable && trig_on && csync != MPC_CS_IMM && !pend_q && !wr_cond) |=> $stable(cond_act_q);
    endproperty
    a_no_early: assert property (p_no_early) else $error("transfer before trigger");

    property p_saw_peak;
        @(posedge clk) disable iff (!rst_n)
        (unit_enable && !carrier_tri && !trig_on && csync != MPC_CS_IMM && !peak_hit) |=> $stable(cond_act_q);
    endproperty
    a_saw_peak: assert property (p_saw_peak) else $error("sawtooth transfer off peak");

    property p_upper_pol;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (upper_out_b == ($past(up_lvl[1]) ~^ $past(pol_up)));
    endproperty
    a_upper_pol: assert property (p_upper_pol) else $error("upper polarity wrong");

    property p_lower_pol;
        @(posedge clk) disable iff (!rst_n)
        (!cond_act_q[`MPC_COND_SEL_LSB + 2]) |=> (lower_out_c == ($past(cond_act_q[4]) ~^ $past(pol_lo)));
    endproperty
    a_lower_pol: assert property (p_lower_pol) else $error("lower fixed level wrong");

    property p_pwm_lowside;
        @(posedge clk) disable iff (!rst_n)
        (cond_act_q[`MPC_COND_SEL_LSB + 1] && cond_act_q[3:2] == 2'b01) |=> (upper_out_b == !$past(pol_up));
    endproperty
    a_pwm_lowside: assert property (p_pwm_lowside) else $error("upper not held off in 01");

    property p_ack_pulse;
        @(posedge clk) disable iff (!rst_n)
        ack_q |=> !ack_q;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule
`default_nettype wire

// file: tb/mpc_gate_model.sv
/*
 * Behavioural inverter gate stage facing the six phase outputs.
 * Assumes the bench tells it the programmed polarity of each leg group.
 */
`timescale 1ns/1ps
`default_nettype none

module mpc_gate_model (
    // Polarity programmed by software
    input  wire logic       pol_h,
    input  wire logic       pol_l,
    // Pins {upper a,b,c, lower a,b,c}
    input  wire logic [5:0] pins,
    // Switch on states, same order
    output logic      [5:0] legs
);
    // A pin at its active level turns the switch on; active low inverts
    assign legs = {pins[5:3] ~^ {3{pol_h}}, pins[2:0] ~^ {3{pol_l}}};
endmodule

`default_nettype wire

// file: tb/motor_pwm_compare_conduction_test.sv
/*
 * Self-checking bench: register bus, phase levels and transfer timing.
 * Assumes the bench plays the carrier logic and the trigger sources.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_defines.svh"

module motor_pwm_compare_conduction_test;
    import mpc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0, seed = 32'h000087AE;
    mpc_word_t   cnt = 16'h0032, prd = 16'h0064;
    logic        tri_s = 1'b1, en = 1'b0, ld = 1'b0, upwm = 1'b0;
    logic        enc = 1'b0, tmr = 1'b0, pol_h = 1'b0, pol_l = 1'b0, ack;
    logic [31:0] rdat;
    wire  [5:0]  pins, legs;
    logic [31:0] eq[$], mq[$];
    int          error_cnt = 0, num_checks = 0;
    logic [10:0] cl [2] = '{11'h724, 11'h71B};
    logic [1:0]  tg [4] = '{2'b01, 2'b10, 2'b01, 2'b00};
    logic [1:0]  cs [4] = '{2'b10, 2'b01, 2'b11, 2'b01};
    logic        tr [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    mpc_word_t   bad[4] = '{16'h0001, 16'h0064, 16'h0033, 16'h0001};
    mpc_word_t   good[4] = '{16'h0064, 16'h0001, 16'h0001, 16'h0064};

    mpc_top uut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .carrier_cnt(cnt),
        .carrier_prd(prd), .carrier_tri(tri_s), .unit_enable(en), .cmp_load(ld), .u_pwm_active(upwm),
        .encoder_interrupt(enc), .timer_interrupt(tmr), .upper_out_a(pins[5]), .upper_out_b(pins[4]),
        .upper_out_c(pins[3]), .lower_out_a(pins[2]), .lower_out_b(pins[1]), .lower_out_c(pins[0])
    );
    mpc_gate_model model (.pol_h(pol_h), .pol_l(pol_l), .pins(pins), .legs(legs));

    initial begin
        forever #25 clk = ~clk;
    end

    // Level before polarity: {upper, lower}; lower PWM is the complement
    function automatic logic [1:0] lvl(logic s, logic [1:0] oc, logic p);
        if (!s) return oc;
        if (oc == 2'b01) return {1'b0, ~p};
        if (oc == 2'b10) return {p, 1'b0};
        return {p, ~p};
    endfunction
    function automatic logic [5:0] exp_legs(logic [10:0] c, logic pu, logic pv, logic pw);
        logic [1:0] u, v, w;
        u = lvl(c[8], c[1:0], pu);
        v = lvl(c[9], c[3:2], pv);
        w = lvl(c[10], c[5:4], pw);
        return {u[1], v[1], w[1], u[0], v[0], w[0]};
    endfunction
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Request held until ack is sampled; the wait is bounded
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
        eq.push_back(e);
        mq.push_back(m);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask
    // Output setting is only changed while the unit is disabled
    task automatic setos(logic [1:0] t, logic ph, logic pl, logic [1:0] c);
        wr(`MPC_ADR_OUTSET, {22'h0, t, 4'h0, ph, pl, c});
        pol_h <= ph;
        pol_l <= pl;
    endtask
    task automatic pins_chk(logic [5:0] e);
        repeat (3) @(posedge clk);
        chk("legs", {26'h0, e}, {26'h0, legs});
    endtask
    task automatic trg(logic [1:0] t);
        @(posedge clk);
        enc <= t[0];
        tmr <= t[1];
        @(posedge clk);
        enc <= 1'b0;
        tmr <= 1'b0;
    endtask
    task automatic pt(mpc_word_t v);
        @(posedge clk);
        cnt <= v;
        repeat (2) @(posedge clk);
        cnt <= 16'h0032;
    endtask

    // ****************************************
    // Read data monitor and watchdog
    // ****************************************
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && eq.size() > 0) begin
            chk("rd_data", eq.pop_front(), rdat & mq.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        pins_chk(6'h00);
        for (int a = 0; a <= 16; a += 4) rd(a[7:0], 32'h0);
        $display("test reset done");
        wr(`MPC_ADR_CMP_V, 32'hFFFFABCD);
        rd(`MPC_ADR_CMP_V, 32'h0000ABCD);
        seed = lfsr(seed);
        wb(1'b1, `MPC_ADR_CMP_W, seed, 4'h3);
        rd(`MPC_ADR_CMP_W, {16'h0, seed[15:0]});
        rd(8'h20, 32'h0);
        wr(`MPC_ADR_OUTSET, 32'hFFFFFFFF);
        rd(`MPC_ADR_OUTSET, `MPC_OUTSET_MASK);
        $display("test registers done");
        // Sync fields set but ignored while disabled, so writes act at once
        for (int p = 0; p < 4; p++) begin
            for (int oc = 0; oc < 4; oc++) begin
                setos(2'b01, p[1], p[0], 2'b10);
                wr(`MPC_ADR_COND, {26'h0, oc[1:0], oc[1:0], oc[1:0]});
                pins_chk(exp_legs({5'h00, oc[1:0], oc[1:0], oc[1:0]}, 1'b0, 1'b0, 1'b0));
            end
        end
        $display("test fixed done");
        setos(2'b00, 1'b1, 1'b1, 2'b00);
        wr(`MPC_ADR_CMP_V, 32'h0000000A);
        wr(`MPC_ADR_CMP_W, 32'h0000FFFF);
        for (int i = 0; i < 4; i++) begin
            cnt <= i[0] ? 16'h0032 : 16'h0005;
            upwm <= i[0];
            wr(`MPC_ADR_COND, {21'h0, cl[i[1]]});
            pins_chk(exp_legs(cl[i[1]], i[0], ~i[0], 1'b1));
        end
        en <= 1'b1;
        wr(`MPC_ADR_CMP_V, 32'h0000003C);
        rd(`MPC_ADR_STATUS, 32'h0, 32'h1000);
        @(posedge clk);
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        rd(`MPC_ADR_STATUS, 32'h1000, 32'h1000);
        en <= 1'b0;
        $display("test pwm done");
        for (int k = 0; k < 4; k++) begin
            setos(tg[k], 1'b1, 1'b1, cs[k]);
            wr(`MPC_ADR_COND, 32'h15 + k);
            tri_s <= tr[k];
            en <= 1'b1;
            wr(`MPC_ADR_COND, 32'h2A + k);
            rd(`MPC_ADR_COND, 32'h2A + k);
            if (tg[k] != 2'b00) begin
                trg(~tg[k]);
                rd(`MPC_ADR_STATUS, 32'h15 + k, 32'hFFF);
                trg(tg[k]);
                rd(`MPC_ADR_STATUS, 32'h815 + k, 32'hFFF);
            end
            pt(bad[k]);
            rd(`MPC_ADR_STATUS, ((tg[k] != 2'b00) ? 32'h800 : 32'h0) | (32'h15 + k), 32'hFFF);
            pt(good[k]);
            rd(`MPC_ADR_STATUS, 32'h2A + k, 32'hFFF);
            en <= 1'b0;
        end
        // Trigger with carrier sync 00 transfers on the trigger itself
        setos(2'b10, 1'b1, 1'b1, 2'b00);
        wr(`MPC_ADR_COND, 32'h3F);
        en <= 1'b1;
        wr(`MPC_ADR_COND, 32'h12);
        trg(2'b01);
        rd(`MPC_ADR_STATUS, 32'h3F, 32'hFFF);
        trg(2'b10);
        rd(`MPC_ADR_STATUS, 32'h12, 32'hFFF);
        en <= 1'b0;
        setos(2'b01, 1'b1, 1'b1, 2'b10);
        en <= 1'b1;
        trg(2'b01);
        rd(`MPC_ADR_STATUS, 32'h800, 32'h800);
        en <= 1'b0;
        rd(`MPC_ADR_STATUS, 32'h0, 32'h800);
        $display("test transfer done");
        conclude();
    end
endmodule

`default_nettype wire
